// >>> hdl/pcfc_consts.svh
// Register offsets, field positions, reset values for the chop and fault slice
`ifndef PCFC_CONSTS_SVH
`define PCFC_CONSTS_SVH

`define PCFC_CARRIER_OFS 4'h0
`define PCFC_DUTY_OFS 4'h4
`define PCFC_FAULT_OFS 4'h8
`define PCFC_CONFIG_OFS 4'hc

`define PCFC_CARRIER_ON_BIT 15
`define PCFC_DIV_MSB 9
`define PCFC_SRC_MSB 7
`define PCFC_SRC_LSB 3
`define PCFC_POL_BIT 2
`define PCFC_HI_OVR_BIT 0
`define PCFC_LO_OVR_BIT 1
`define PCFC_LATCH_CLR_BIT 8

`define PCFC_CARRIER_RST 16'h0000
`define PCFC_DUTY_RST 16'h0000
`define PCFC_FAULT_RST 16'h00fb
`define PCFC_CONFIG_RST 16'h0000
`define PCFC_PRESCALE_RST 3'h0

`define PCFC_RESP_OKAY 2'h0
`define PCFC_RESP_SLVERR 2'h2

`endif

// >>> hdl/pcfc_pkg.sv
// Types shared by the chop and fault slice
package pcfc_pkg;
    typedef enum logic [1:0] {
        PCFC_MODE_LATCH = 2'b00,
        PCFC_MODE_CYCLE = 2'b01,
        PCFC_MODE_RSVD = 2'b10,
        PCFC_MODE_OFF = 2'b11
    } pcfc_mode_t;
endpackage

// >>> hdl/pcfc_top.sv
// Chop carrier generator, master duty register and fault override control with AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "pcfc_consts.svh"

// Notes on behaviour
// - Carrier generator runs only while its enable bit 15 is set.
// - Carrier toggles at clock over prescale plus one, then over divider plus one.
// - Carrier register bits 14..10 ignore writes and read zero.
// - Sixteen-bit master duty register, read/write, zero after reset, shared outward.
// - Five-bit source field picks fault 1..32; default 11111, 11110 reserved.
// - Polarity bit set makes the chosen fault active low.
// - Mode 11 ignores the fault input; mode 10 is reserved.
// - Mode 01 overrides both outputs only while the fault is active.
// - Mode 00 latches the override until software clears it.
module pcfc_top
    import pcfc_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // AXI4-Lite write address and data
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // PWM side
    input wire logic [31:0] fault_in,
    input wire logic pwm_high_in,
    input wire logic pwm_low_in,
    output logic pwm_high_out,
    output logic pwm_low_out,
    output logic carrier_out,
    output logic [15:0] master_duty,
    output logic fault_active
);

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [15:0] carrier_q, carrier_d;
    logic [15:0] duty_q, duty_d;
    logic [15:0] fault_q, fault_d;
    logic [15:0] config_q, config_d;
    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [3:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [1:0] wstrb_q, wstrb_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic have_aw, have_w, do_write, latch_clr;
    logic latched_q, latched_d;
    logic [15:0] wmask;

    // Address and data are caught in either order; ready drops once held
    assign have_aw = !awready_q;
    assign have_w = !wready_q;
    assign do_write = have_aw && have_w && !bvalid_q;
    assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign latch_clr = do_write && awaddr_q == `PCFC_CONFIG_OFS && wstrb_q[1] && wdata_q[`PCFC_LATCH_CLR_BIT];

    always_comb begin
        carrier_d = carrier_q;
        duty_d = duty_q;
        fault_d = fault_q;
        config_d = config_q;
        awready_d = awready_q;
        wready_d = wready_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            awaddr_d = s_axi_awaddr;
            awready_d = 1'b0;
        end
        if (s_axi_wvalid && wready_q) begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb[1:0];
            wready_d = 1'b0;
        end
        if (do_write) begin
            bvalid_d = 1'b1;
            bresp_d = `PCFC_RESP_OKAY;
            case (awaddr_q)
                `PCFC_CARRIER_OFS: begin
                    // Bits 14..10 are not stored
                    carrier_d = ((carrier_q & ~wmask) | (wdata_q[15:0] & wmask)) & 16'h83ff;
                end
                `PCFC_DUTY_OFS: begin
                    duty_d = (duty_q & ~wmask) | (wdata_q[15:0] & wmask);
                end
                `PCFC_FAULT_OFS: begin
                    fault_d = (fault_q & ~wmask) | (wdata_q[15:0] & wmask);
                end
                `PCFC_CONFIG_OFS: begin
                    // Bit 8 is a self-clearing latch release, not stored
                    config_d = ((config_q & ~wmask) | (wdata_q[15:0] & wmask)) & 16'h0007;
                end
                default: begin
                    bresp_d = `PCFC_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
    end

    always_comb begin
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = `PCFC_RESP_OKAY;
            case (s_axi_araddr)
                `PCFC_CARRIER_OFS: rdata_d = {16'h0000, carrier_q};
                `PCFC_DUTY_OFS: rdata_d = {16'h0000, duty_q};
                `PCFC_FAULT_OFS: rdata_d = {16'h0000, fault_q};
                `PCFC_CONFIG_OFS: rdata_d = {16'h0000, config_q[15:9], latched_q, config_q[7:0]};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `PCFC_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Carrier generator
    // ---------------------------------------------------------------
    logic [2:0] prescale;
    logic [2:0] pre_cnt_q, pre_cnt_d;
    logic [9:0] div_cnt_q, div_cnt_d;
    logic carrier_wave_q, carrier_wave_d;
    logic carrier_on;

    assign carrier_on = carrier_q[`PCFC_CARRIER_ON_BIT];
    // Prescale code n divides by n+1; held in the fault register upper bits
    assign prescale = fault_q[10:8];

    always_comb begin
        pre_cnt_d = pre_cnt_q;
        div_cnt_d = div_cnt_q;
        carrier_wave_d = carrier_wave_q;
        if (!carrier_on) begin
            pre_cnt_d = 3'h0;
            div_cnt_d = 10'h000;
            carrier_wave_d = 1'b0;
        end else if (pre_cnt_q >= prescale) begin
            pre_cnt_d = 3'h0;
            // One carrier half period spans divider+1 prescaled ticks
            if (div_cnt_q >= carrier_q[`PCFC_DIV_MSB:0]) begin
                div_cnt_d = 10'h000;
                carrier_wave_d = !carrier_wave_q;
            end else begin
                div_cnt_d = div_cnt_q + 10'h001;
            end
        end else begin
            pre_cnt_d = pre_cnt_q + 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // Fault selection and override
    // ---------------------------------------------------------------
    pcfc_mode_t mode;
    logic [4:0] src_sel;
    logic fault_raw, fault_hit;
    logic fault_act_q, fault_act_d;
    logic hi_q, hi_d, lo_q, lo_d;

    assign mode = pcfc_mode_t'(fault_q[1:0]);
    assign src_sel = fault_q[`PCFC_SRC_MSB:`PCFC_SRC_LSB];
    // Code n picks fault n+1; reserved 11110 still maps to an input bit
    assign fault_raw = fault_in[src_sel];
    assign fault_hit = fault_raw ^ fault_q[`PCFC_POL_BIT];

    always_comb begin
        latched_d = latched_q;
        fault_act_d = 1'b0;
        case (mode)
            PCFC_MODE_LATCH: begin
                // Fresh fault wins over a same-cycle release
                if (fault_hit) begin
                    latched_d = 1'b1;
                end else if (latch_clr) begin
                    latched_d = 1'b0;
                end
                fault_act_d = fault_hit || latched_q;
            end
            PCFC_MODE_CYCLE: begin
                latched_d = 1'b0;
                fault_act_d = fault_hit;
            end
            default: begin
                // Off and reserved codes ignore the input
                latched_d = 1'b0;
                fault_act_d = 1'b0;
            end
        endcase
        hi_d = fault_act_d ? config_q[`PCFC_HI_OVR_BIT] : pwm_high_in;
        lo_d = fault_act_d ? config_q[`PCFC_LO_OVR_BIT] : pwm_low_in;
    end

    // ---------------------------------------------------------------
    // State registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            carrier_q <= `PCFC_CARRIER_RST;
            duty_q <= `PCFC_DUTY_RST;
            fault_q <= `PCFC_FAULT_RST;
            config_q <= `PCFC_CONFIG_RST;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 2'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
            pre_cnt_q <= 3'h0;
            div_cnt_q <= 10'h000;
            carrier_wave_q <= 1'b0;
            latched_q <= 1'b0;
            fault_act_q <= 1'b0;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
        end else if (clk_en) begin
            carrier_q <= carrier_d;
            duty_q <= duty_d;
            fault_q <= fault_d;
            config_q <= config_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            pre_cnt_q <= pre_cnt_d;
            div_cnt_q <= div_cnt_d;
            carrier_wave_q <= carrier_wave_d;
            latched_q <= latched_d;
            fault_act_q <= fault_act_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign carrier_out = carrier_wave_q;
    assign master_duty = duty_q;
    assign pwm_high_out = hi_q;
    assign pwm_low_out = lo_q;
    assign fault_active = fault_act_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_fault_seen;
        clk_en && fault_hit && mode == PCFC_MODE_LATCH;
    endsequence
    sequence s_fault_gone;
        clk_en && !fault_hit && !latch_clr && mode == PCFC_MODE_LATCH;
    endsequence

    a_carrier_off_idle: assert property (!carrier_on ##1 1 |-> !carrier_out || !$past(clk_en))
        else $error("carrier toggled while disabled");
    a_counter_cleared: assert property ($past(clk_en) && !$past(carrier_on) |-> div_cnt_q == 10'h000)
        else $error("divider not cleared while disabled");
    a_div_bound: assert property (carrier_on |-> div_cnt_q <= carrier_q[9:0] || $changed(carrier_q))
        else $error("divider count exceeds setting");
    a_reserved_zero: assert property (carrier_q[14:10] == 5'h00)
        else $error("carrier bits 14..10 not zero");
    a_duty_out: assert property (clk_en && do_write && awaddr_q == `PCFC_DUTY_OFS && wstrb_q == 2'h3 |=> master_duty == $past(wdata_q[15:0]))
        else $error("duty output mismatch");
    a_mode_off_quiet: assert property (clk_en && mode[1] |=> !fault_active)
        else $error("fault acted in ignored mode");
    a_cycle_follow: assert property (clk_en && mode == PCFC_MODE_CYCLE |=> fault_active == $past(fault_raw ^ fault_q[2]))
        else $error("cycle mode did not follow fault");
    a_latch_hold: assert property (s_fault_seen ##1 s_fault_gone |=> fault_active)
        else $error("latched fault released early");
    a_override_val: assert property (clk_en && fault_act_d |=> pwm_high_out == $past(config_q[0]))
        else $error("high override wrong");

endmodule
`default_nettype wire

// >>> tb/pcfc_stage_model.sv
// Fault sensing front end of the power stage feeding the slice's fault lines
`timescale 1ns/1ps
`default_nettype none
module pcfc_stage_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Trip control from the bench
    input wire logic [4:0] trip_idx,
    input wire logic trip_on,
    input wire logic trip_low,
    // Fault lines
    output logic [31:0] fault_in
);
    logic [31:0] fault_d;
    logic [31:0] fault_q;

    // Idle lines sit at the inactive level of the chosen sensor polarity
    always_comb begin
        fault_d = {32{trip_low}};
        if (trip_on) begin
            fault_d[trip_idx] = ~trip_low;
        end
    end

    // Comparator output is registered, so a trip lands one cycle late
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fault_q <= 32'h0;
        end else begin
            fault_q <= fault_d;
        end
    end

    assign fault_in = fault_q;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the chop and fault slice
`timescale 1ns/1ps
`default_nettype none
module tb
    import pcfc_pkg::*;
;
    logic core_clk = 1'h0, nrst = 1'h0, clk_en = 1'h1, hi_in = 1'h0, lo_in = 1'h1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, hi_o, lo_o, car, fact;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, fin;
    logic [15:0] mduty;
    logic [4:0] trip_idx = 5'h0;
    logic trip_on = 1'h0, trip_low = 1'h0;
    int errors = 0, comparisons = 0;

    always #10 core_clk = ~core_clk;

    pcfc_stage_model stage (.core_clk(core_clk), .nrst(nrst), .trip_idx(trip_idx), .trip_on(trip_on),
        .trip_low(trip_low), .fault_in(fin));
    pcfc_top dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fault_in(fin), .pwm_high_in(hi_in), .pwm_low_in(lo_in), .pwm_high_out(hi_o),
        .pwm_low_out(lo_o), .carrier_out(car), .master_duty(mduty), .fault_active(fact));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Register bus master
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        int n;
        n = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 50);
        bready <= 1'h0;
        if (n >= 50) begin
            errors++;
            wrap_up();
        end
        chk({30'h0, bresp}, 32'h0, "write response");
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        if (n >= 50) begin
            errors++;
            wrap_up();
        end
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d, exp, "read data");
        chk({30'h0, r}, 32'h0, "read response");
    endtask

    // Expect {fault_active, high, low} once model and output registers settle
    task automatic outs(input logic [2:0] e);
        tick(3);
        chk({29'h0, fact, hi_o, lo_o}, {29'h0, e}, "pwm outputs");
    endtask

    task automatic half(output int n);
        logic c;
        n = 0;
        c = car;
        while (car === c && n < 200) begin
            tick(1);
            n++;
        end
    endtask

    function automatic logic [31:0] freg(input logic [4:0] s, input logic p, input logic [1:0] m);
        return {21'h0, 3'h1, s, p, m};
    endfunction

    initial begin
        int n;
        logic [31:0] d;
        logic [1:0] r;
        logic [4:0] codes [4] = '{5'h00, 5'h05, 5'h1d, 5'h1f};
        repeat (20000) @(posedge core_clk);
        errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [31:0] d;
        logic [1:0] r;
        logic [4:0] codes [4] = '{5'h00, 5'h05, 5'h1d, 5'h1f};
        repeat (8) @(posedge core_clk);
        nrst <= 1'h1;
        tick(1);
        rdchk(4'h0, 32'h0);
        rdchk(4'h4, 32'h0);
        rdchk(4'h8, 32'hfb);
        rdchk(4'hc, 32'h0);
        chk({16'h0, mduty}, 32'h0, "duty port");
        $display("test reset values done");
        axi_wr(4'h0, 32'hffff);
        rdchk(4'h0, 32'h83ff);
        axi_wr(4'h0, 32'h0);
        axi_wr(4'h4, 32'h1234);
        rdchk(4'h4, 32'h1234);
        chk({16'h0, mduty}, 32'h1234, "duty port");
        // Low byte lane only
        axi_wr(4'h4, 32'hffff, 4'h1);
        rdchk(4'h4, 32'h12ff);
        axi_rd(4'h2, d, r);
        chk({30'h0, r}, 32'h2, "unmapped response");
        chk(d, 32'h0, "unmapped data");
        $display("test registers done");
        // Fault mode off before config and carrier are set, so the outputs stay pass-through
        axi_wr(4'h8, freg(5'h1f, 1'h0, PCFC_MODE_OFF));
        axi_wr(4'hc, 32'h1);
        axi_wr(4'h0, 32'h8002);
        half(n);
        half(n);
        chk(n, 6, "carrier half period");
        half(n);
        chk(n, 6, "carrier half period");
        // Frozen cycles must not count toward the half period
        @(posedge core_clk);
        clk_en <= 1'h0;
        repeat (10) @(posedge core_clk);
        clk_en <= 1'h1;
        half(n);
        chk(n, 5, "carrier after freeze");
        axi_wr(4'h0, 32'h2);
        tick(2);
        repeat (16) begin
            chk({31'h0, car}, 32'h0, "carrier stopped");
            tick(1);
        end
        $display("test carrier done");
        foreach (codes[i]) begin
            axi_wr(4'h8, freg(codes[i], 1'h0, PCFC_MODE_CYCLE));
            trip_idx <= codes[i] ^ 5'h1;
            trip_on <= 1'h1;
            outs(3'b001);
            trip_idx <= codes[i];
            outs(3'b110);
            trip_on <= 1'h0;
            outs(3'b001);
        end
        $display("test fault sources done");
        axi_wr(4'h8, freg(5'h03, 1'h1, PCFC_MODE_CYCLE));
        trip_low <= 1'h1;
        trip_idx <= 5'h03;
        outs(3'b001);
        trip_on <= 1'h1;
        outs(3'b110);
        trip_on <= 1'h0;
        outs(3'b001);
        axi_wr(4'h8, freg(5'h03, 1'h0, PCFC_MODE_OFF));
        trip_low <= 1'h0;
        $display("test polarity done");
        axi_wr(4'h8, freg(5'h03, 1'h0, PCFC_MODE_RSVD));
        trip_on <= 1'h1;
        hi_in <= 1'h1;
        lo_in <= 1'h0;
        outs(3'b010);
        trip_on <= 1'h0;
        hi_in <= 1'h0;
        lo_in <= 1'h1;
        axi_wr(4'h8, freg(5'h03, 1'h0, PCFC_MODE_OFF));
        trip_on <= 1'h1;
        outs(3'b001);
        trip_on <= 1'h0;
        $display("test ignored modes done");
        axi_wr(4'h8, freg(5'h03, 1'h0, PCFC_MODE_LATCH));
        trip_on <= 1'h1;
        outs(3'b110);
        trip_on <= 1'h0;
        outs(3'b110);
        tick(10);
        outs(3'b110);
        rdchk(4'hc, 32'h101);
        axi_wr(4'hc, 32'h101);
        outs(3'b001);
        $display("test latched mode done");
        wrap_up();
    end
endmodule
`default_nettype wire
